// ---- rtl/lpt_defs.vh ----
// register map, field positions and timing constants of the protocol timer
`ifndef LPT_DEFS_VH
`define LPT_DEFS_VH
`define LPT_TIMER_CTRL_OFS   8'h1c
`define LPT_IRQ_STATUS_OFS   8'h08
`define LPT_IRQ_MASK_OFS     8'h0c
`define LPT_RUN_BIT          31
`define LPT_REPEAT_BIT       30
`define LPT_BRSTART_BIT      29
`define LPT_PRELOAD_MSB      23
`define LPT_PRELOAD_W        24
`define LPT_EXPIRE_BIT       20
`define LPT_CTRL_RESET       32'h00000000
`define LPT_UNIT_PS          80140
`define LPT_CLK_PERIOD_PS    100000
`define LPT_UNIT_CYCLES      (((`LPT_UNIT_PS) / (`LPT_CLK_PERIOD_PS)) < 1 ? 1 : ((`LPT_UNIT_PS) / (`LPT_CLK_PERIOD_PS)))
`endif

// ---- rtl/lpt_sync.v ----
// two-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
`default_nettype none
module lpt_sync (
  input  wire ref_clk,
  input  wire rst,
  input  wire clkEn,
  input  wire asyncIn,
  output wire syncOut
);
  reg stage1_reg;
  reg stage2_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      stage1_reg <= 1'h0;
      stage2_reg <= 1'h0;
    end else if (clkEn) begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end
  assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// ---- rtl/lpt_unit_tick.v ----
// timing unit tick generator
`timescale 1ns/100ps
`default_nettype none
module lpt_unit_tick #(
  parameter CYCLES = 1
) (
  input  wire ref_clk,
  input  wire rst,
  input  wire clkEn,
  input  wire restart,
  output wire tick
);
  reg  [15:0] divCnt_reg;
  wire        atEnd;
  assign atEnd = (divCnt_reg == CYCLES[15:0] - 16'h0001);
  always @(posedge ref_clk) begin
    if (rst) begin
      divCnt_reg <= 16'h0000;
    end else if (clkEn) begin
      if (restart || atEnd) begin
        divCnt_reg <= 16'h0000;
      end else begin
        divCnt_reg <= divCnt_reg + 16'h0001;
      end
    end
  end
  assign tick = atEnd && !restart;
endmodule
`default_nettype wire

// ---- rtl/lpt_timer.v ----
// protocol timer with control register, expiry status and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "lpt_defs.vh"
// How it works
// [RULE1] run bit one starts, zero stops
// [RULE2] repeat zero one-shot, one reloads forever
// [RULE3] bus-reset start bit starts on bus reset
// [RULE4] start value from 24-bit preload field
// [RULE5] preload msb high, lsb at bit zero
// [RULE6] count in hidden copy, preload untouched
// [RULE7] decrement once per timing unit
// [RULE8] zero sets expiry flag, enable gates interrupt
// [RULE9] bus-reset mode ignores run bit
// [RULE10] repeat bit still works in bus-reset mode
// [RULE11] uncleared flag never blocks reloading
// [RULE12] expiry flag is status bit 20
// [RULE13] new bus reset reloads, no interrupt
// [RULE14] load counter before first decrement
module lpt_timer #(
  parameter PRELOAD_W = `LPT_PRELOAD_W,
  parameter UNIT_CYCLES = `LPT_UNIT_CYCLES
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrStb,
  input  wire        regRdStb,
  output wire [31:0] regRdData,
  input  wire        busResetIn,
  output wire        timerIrq,
  output wire        timerRunning
);
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam [31:0]          RESVD_MASK  = 32'h0000001f << `LPT_PRELOAD_W;
  localparam [31:0]          CTRL_MASK   = ~RESVD_MASK;
  localparam [31:0]          EXPIRE_MASK = 32'h00000001 << `LPT_EXPIRE_BIT;
  localparam [31:0]          ZERO_WORD   = 32'h00000000;
  localparam [7:0]           CTRL_OFS    = `LPT_TIMER_CTRL_OFS;
  localparam [7:0]           STATUS_OFS  = `LPT_IRQ_STATUS_OFS;
  localparam [7:0]           MASK_OFS    = `LPT_IRQ_MASK_OFS;
  localparam [PRELOAD_W-1:0] COUNT_ZERO  = {PRELOAD_W{1'h0}};
  localparam [PRELOAD_W-1:0] COUNT_ONE   = {{(PRELOAD_W-1){1'h0}}, 1'h1};

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg  [31:0]          ctrl_reg;
  reg  [31:0]          ctrl_next;
  reg  [31:0]          status_reg;
  reg  [31:0]          status_next;
  reg  [31:0]          mask_reg;
  reg  [31:0]          mask_next;
  reg  [31:0]          rdData_reg;
  reg  [31:0]          rdData_next;
  reg  [PRELOAD_W-1:0] count_reg;
  reg  [PRELOAD_W-1:0] count_next;
  reg                  run_reg;
  reg                  run_next;
  reg                  busRstDly_reg;

  // ----------------------------------------
  // decode nets
  // ----------------------------------------
  wire                 busRstSync;
  wire                 busRstStart;
  wire                 ctrlWr;
  wire                 statusWr;
  wire                 maskWr;
  wire                 wrBrMode;
  wire                 wrRun;
  wire                 runStart;
  wire                 runStop;
  wire                 brStart;
  wire                 startEv;
  wire                 unitTick;
  wire                 countZero;
  wire                 expire;
  wire                 brMode;
  wire                 repeatOn;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function [PRELOAD_W-1:0] preload_of;
    input [31:0] word;
    begin
      preload_of = word[PRELOAD_W-1:0];
    end
  endfunction

  function count_is_zero;
    input [PRELOAD_W-1:0] v;
    begin
      count_is_zero = (v == COUNT_ZERO);
    end
  endfunction

  function [31:0] w1c_next;
    input [31:0] cur;
    input [31:0] clr;
    input        set;
    begin
      w1c_next = (cur & ~clr) | (set ? EXPIRE_MASK : ZERO_WORD);
    end
  endfunction

  function [31:0] read_mux;
    input [7:0]  a;
    input [31:0] c;
    input [31:0] s;
    input [31:0] m;
    begin
      read_mux = ZERO_WORD;
      if (hit(a, CTRL_OFS)) begin
        read_mux = c;
      end
      if (hit(a, STATUS_OFS)) begin
        read_mux = s;
      end
      if (hit(a, MASK_OFS)) begin
        read_mux = m;
      end
    end
  endfunction

  // ----------------------------------------
  // bus reset input
  // ----------------------------------------
  lpt_sync lpt_sync_i (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .asyncIn (busResetIn),
    .syncOut (busRstSync)
  );

  always @(posedge ref_clk) begin
    if (rst) begin
      busRstDly_reg <= 1'h0;
    end else if (clkEn) begin
      busRstDly_reg <= busRstSync;
    end
  end
  assign busRstStart = busRstSync && !busRstDly_reg;

  // ----------------------------------------
  // unit tick
  // ----------------------------------------
  lpt_unit_tick #(
    .CYCLES (UNIT_CYCLES)
  ) lpt_unit_tick_i (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .restart (startEv),
    .tick    (unitTick)
  );

  // ----------------------------------------
  // address and start decode
  // ----------------------------------------
  assign ctrlWr    = regWrStb && hit(regAddr, CTRL_OFS);
  assign statusWr  = regWrStb && hit(regAddr, STATUS_OFS);
  assign maskWr    = regWrStb && hit(regAddr, MASK_OFS);
  assign wrBrMode  = regWrData[`LPT_BRSTART_BIT];
  assign wrRun     = regWrData[`LPT_RUN_BIT];
  assign brMode    = ctrl_reg[`LPT_BRSTART_BIT];
  assign repeatOn  = ctrl_reg[`LPT_REPEAT_BIT];
  assign runStart  = ctrlWr && !wrBrMode && wrRun; // [RULE1] [RULE9]
  assign runStop   = ctrlWr && !wrBrMode && !wrRun; // [RULE1] [RULE9]
  assign brStart   = brMode && busRstStart; // [RULE3] [RULE13]
  assign startEv   = runStart || brStart; // [RULE3] [RULE14]
  assign countZero = count_is_zero(count_reg);
  assign expire    = run_reg && unitTick && countZero && !startEv; // [RULE8]

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    count_next = count_reg;
    run_next   = run_reg;
    if (startEv) begin
      count_next = ctrlWr ? preload_of(regWrData) : preload_of(ctrl_reg); // [RULE4] [RULE5] [RULE14]
      run_next   = 1'h1;
    end else if (runStop) begin
      run_next   = 1'h0;
    end else if (expire) begin
      count_next = preload_of(ctrl_reg); // [RULE2] [RULE10] [RULE11]
      run_next   = repeatOn; // [RULE2] [RULE10]
    end else if (run_reg && unitTick) begin
      count_next = count_reg - COUNT_ONE; // [RULE6] [RULE7]
    end
  end

  always @* begin
    ctrl_next = ctrl_reg;
    if (ctrlWr) begin
      ctrl_next = regWrData & CTRL_MASK;
    end
  end

  always @* begin
    mask_next = mask_reg;
    if (maskWr) begin
      mask_next = regWrData & EXPIRE_MASK;
    end
  end

  always @* begin
    status_next = status_reg;
    if (statusWr) begin
      status_next = w1c_next(status_reg, regWrData, expire); // [RULE8] [RULE12]
    end else if (expire) begin
      status_next = status_reg | EXPIRE_MASK; // [RULE8] [RULE12]
    end
  end

  always @* begin
    rdData_next = ZERO_WORD;
    if (regRdStb) begin
      rdData_next = read_mux(regAddr, ctrl_reg, status_reg, mask_reg);
    end
  end

  // ----------------------------------------
  // counter and run flag
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= COUNT_ZERO;
      run_reg   <= 1'h0;
    end else if (clkEn) begin
      count_reg <= count_next;
      run_reg   <= run_next;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= `LPT_CTRL_RESET;
    end else if (clkEn) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------
  // mask register
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      mask_reg <= ZERO_WORD;
    end else if (clkEn) begin
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      status_reg <= ZERO_WORD;
    end else if (clkEn) begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      rdData_reg <= ZERO_WORD;
    end else if (clkEn) begin
      rdData_reg <= rdData_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdData    = rdData_reg;
  assign timerIrq     = |(status_reg & mask_reg); // [RULE8]
  assign timerRunning = run_reg;
endmodule
`default_nettype wire

// ---- verification/lpt_timer_checker.sv ----
// port assertions for the protocol timer
`timescale 1ns/100ps
`default_nettype none
module lpt_timer_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic        busResetIn,
  input wire logic        timerIrq,
  input wire logic        timerRunning
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire cw = regWrStb && clkEn && regAddr == 8'h1c;
  a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
    else $error("read data not idle");
  a_ctrl_resvd_zero: assert property ($past(regRdStb && regAddr == 8'h1c)
    |-> regRdData[28:24] == 5'h00) else $error("reserved bits set");
  a_run_start: assert property (cw && !regWrData[29] && regWrData[31]
    |=> timerRunning) else $error("no start");
  a_run_stop: assert property (cw && !regWrData[29] && !regWrData[31]
    |=> !timerRunning) else $error("no stop");
  a_oneshot_len: assert property (cw && regWrData == 32'h80000002
    |=> timerRunning [*3] ##1 !timerRunning) else $error("one-shot length");
  a_brst_no_stop: assert property (cw && regWrData[30:29] == 2'h3 && timerRunning
    |=> timerRunning) else $error("run bit stopped timer");
  a_irq_rise: assert property ($rose(timerIrq) |-> $past(timerRunning)
    || $past(regWrStb && regAddr == 8'h0c)) else $error("irq without cause");
  a_irq_fall: assert property ($fell(timerIrq) |-> $past(regWrStb) || $past(rst))
    else $error("irq dropped alone");
endmodule
bind lpt_timer lpt_timer_checker lpt_timer_checker_i (.ref_clk(ref_clk), .rst(rst),
  .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .busResetIn(busResetIn),
  .timerIrq(timerIrq), .timerRunning(timerRunning));
`default_nettype wire

// ---- verification/lpt_timer_tb.sv ----
// self-checking bench for the protocol timer
`timescale 1ns/100ps
`default_nettype none
module lpt_timer_tb;
  logic        ref_clk = 1'h0, rst = 1'h1, clkEn = 1'h1;
  logic        regWrStb = 1'h0, regRdStb = 1'h0, busResetIn = 1'h0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  wire  [31:0] regRdData;
  wire         timerIrq, timerRunning;
  int          n_fail = 0, checks_done = 0, n;
  always #50 ref_clk = ~ref_clk;
  lpt_timer lpt_timer_i (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .busResetIn(busResetIn), .timerIrq(timerIrq), .timerRunning(timerRunning));
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'h1;
    @(posedge ref_clk);
    regWrStb <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'h1;
    @(posedge ref_clk);
    regRdStb <= 1'h0;
    #1 chk(regRdData, e);
  endtask
  task wi();
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      #1;
    end while (timerIrq !== 1'h1 && n < 40);
    if (timerIrq !== 1'h1) begin
      n_fail++;
      $display("ERROR %0t no interrupt", $time);
    end
  endtask
  task bus_rst(input logic v);
    @(posedge ref_clk);
    busResetIn <= v;
  endtask
  task t_regs();
    rd(8'h1c, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h1c, 32'h5fa5a5a5);
    rd(8'h1c, 32'h40a5a5a5);
    $display("t_regs done");
  endtask
  task t_oneshot();
    wr(8'h0c, 32'h00100000);
    wr(8'h1c, 32'h80000002);
    wi();
    chk(n, 3);
    rd(8'h08, 32'h00100000);
    chk(timerRunning, 0);
    rd(8'h1c, 32'h80000002);
    wr(8'h08, 32'h00100000);
    rd(8'h08, 32'h0);
    $display("t_oneshot done");
  endtask
  task t_repeat();
    wr(8'h1c, 32'hc0000003);
    wi();
    chk(n, 4);
    repeat (12) @(posedge ref_clk);
    #1 chk(timerRunning, 1);
    wr(8'h0c, 32'h0);
    #1 chk(timerIrq, 0);
    wr(8'h1c, 32'h40000003);
    #1 chk(timerRunning, 0);
    wr(8'h08, 32'h00100000);
    wr(8'h0c, 32'h00100000);
    $display("t_repeat done");
  endtask
  task t_brst();
    wr(8'h1c, 32'ha0000009);
    repeat (3) @(posedge ref_clk);
    #1 chk(timerRunning, 0);
    bus_rst(1'h1);
    repeat (4) @(posedge ref_clk);
    #1 chk(timerRunning, 1);
    bus_rst(1'h0);
    repeat (2) @(posedge ref_clk);
    bus_rst(1'h1);
    wi();
    chk(n, 13);
    chk(timerRunning, 0);
    wr(8'h08, 32'h00100000);
    bus_rst(1'h0);
    wr(8'h1c, 32'h60000009);
    bus_rst(1'h1);
    repeat (4) @(posedge ref_clk);
    wr(8'h1c, 32'h60000009);
    #1 chk(timerRunning, 1);
    repeat (15) @(posedge ref_clk);
    #1 chk(timerRunning, 1);
    $display("t_brst done");
  endtask
  task t_freeze();
    wr(8'h1c, 32'h00000003);
    wr(8'h08, 32'h00100000);
    wr(8'h1c, 32'h80000003);
    @(posedge ref_clk);
    clkEn <= 1'h0;
    repeat (5) @(posedge ref_clk);
    clkEn <= 1'h1;
    wi();
    chk(n, 3);
    chk(timerRunning, 0);
    $display("t_freeze done");
  endtask
  task t_reset();
    wr(8'h1c, 32'hc0000005);
    repeat (3) @(posedge ref_clk);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    #1 chk(timerRunning, 0);
    chk(timerIrq, 0);
    rd(8'h1c, 32'h0);
    rd(8'h0c, 32'h0);
    $display("t_reset done");
  endtask
  task final_report();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    t_regs();
    t_oneshot();
    t_repeat();
    t_brst();
    t_freeze();
    t_reset();
    final_report();
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
